// File: lpv_pkg.sv
// Constants, register offsets, field positions and reset values of the lane pattern verifier.
// Assumes a device register port of 8-bit data and 8-bit addresses, one register per address.
//
// What this block does
// - Per-lane sync pulse bit, read-only status.
// - Load high passes settings to lane verifier.
// - Load falling holds captured lane settings.
// - Per-lane mismatch flag from verifier.
// - Per-lane search or training in progress.
// - custom_len_20 picks 16 or 20 bits.
// - prbs_length_sel picks the polynomial length.
// - pattern_type_sel picks verifier operating mode.
// - Custom bits 19:16 used only when 20.
// - lane_align_done shows lane alignment complete.
// - Counters clear on error_count_clear rising edge.
// - latched_flag_clear write clears latched flags.
// - test_irq_source_sel picks test flag condition.
// - Per-lane datapath_check_enable turns checking on.
// - datapath_check_sel picks reported error kind.
// - Per-lane latched test flag captures condition.
// - Per-lane 12-bit error count, two registers.
// - Live test flag per lane beside latched.
package lpv_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int LANES   = 4;    // Receive lanes
	localparam int CNT_W   = 12;   // Error count width
	localparam int CP_W    = 20;   // Custom pattern width
	localparam int TO_W    = 3;    // Verifier timeout control width
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_SYNC_LOAD  = 8'h0e; // Sync status and load strobes
	localparam logic [7:0] OFS_RESULT     = 8'h0f; // Mismatch and search status
	localparam logic [7:0] OFS_PAT_CFG    = 8'h10; // Pattern configuration
	localparam logic [7:0] OFS_CP_LOW     = 8'h11; // Custom pattern 7:0
	localparam logic [7:0] OFS_CP_MID     = 8'h12; // Custom pattern 15:8
	localparam logic [7:0] OFS_CP_HIGH    = 8'h13; // Custom pattern 19:16
	localparam logic [7:0] OFS_RETAIN     = 8'h14; // Retain threshold
	localparam logic [7:0] OFS_TEST_CTL   = 8'h15; // Test control and status
	localparam logic [7:0] OFS_DP_CTL     = 8'h16; // Datapath check control
	localparam logic [7:0] OFS_TEST_FLAGS = 8'h17; // Latched and live test flags
	localparam logic [7:0] OFS_CNT_BASE   = 8'h18; // Lane 0 count low; two per lane
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_CP20     = 7;   // custom_len_20 in pattern configuration
	localparam int POS_LEN      = 3;   // prbs_length_sel low bit
	localparam int POS_ALIGN    = 7;   // lane_align_done in test control
	localparam int POS_CNT_CLR  = 4;   // error_count_clear in test control
	localparam int POS_FLAG_CLR = 3;   // latched_flag_clear in test control
	localparam int POS_HI_NIB   = 4;   // Upper nibble of split registers
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]      RST_BYTE = 8'h00; // All register bytes
	localparam logic [2:0]      RST_SEL3 = 3'h0;  // All 3-bit selects
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff; // Saturation value
	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PT_DISABLED = 3'b000, // No checking
		PT_PRBS     = 3'b001, // Pseudo-random
		PT_CLOCK    = 3'b010, // Clock pattern
		PT_CUSTOM   = 3'b011  // Custom pattern; 1xx timing only
	} lpv_pat_e;
	typedef enum logic [2:0] {
		DC_DATA_ERR  = 3'b000, // Disparity or data errors
		DC_BUF_ERR   = 3'b001, // Buffer errors
		DC_BUF_OVF   = 3'b010, // Buffer overflow
		DC_BUF_UNF   = 3'b011, // Buffer underflow
		DC_ALIGN     = 3'b100  // Alignment status; 101-111 reserved
	} lpv_dpsel_e;
	typedef enum logic [2:0] {
		TS_MISMATCH  = 3'b000, // Verifier mismatch
		TS_SEARCH    = 3'b001, // Search in progress
		TS_SYNC      = 3'b010, // Sync pulse
		TS_DATAPATH  = 3'b011  // Datapath condition; others none
	} lpv_tsel_e;
endpackage

// File: lpv_top.sv
// Lane pattern verifier register block: settings to four receive verifiers, status and error counts back.
// Assumes one clock, lane status already synchronous, and an external front end driving the register port.
`timescale 1ns/1ps
module lpv_top
	import lpv_pkg::*;
(
	input  wire logic                  clk_sys_in,                 // 20 MHz system clock
	input  wire logic                  rst_n_in,                   // Asynchronous reset, active low
	input  wire logic                  clk_en_in,                  // Freezes all state while low
	input  wire logic [7:0]            reg_addr_in,                // Register offset
	input  wire logic                  reg_wr_in,                  // Write strobe
	input  wire logic [7:0]            reg_wdata_in,               // Write data
	input  wire logic                  reg_rd_in,                  // Read strobe
	output logic      [7:0]            reg_rdata_out,              // Read data, one cycle after strobe
	input  wire logic [TO_W-1:0]       verifier_timeout_ctl_in,    // Timeout setting for verifiers
	input  wire logic [LANES-1:0]      pattern_sync_pulse_in,      // Sync pulse from each verifier
	input  wire logic [LANES-1:0]      mismatch_in,                // Mismatch seen by each verifier
	input  wire logic [LANES-1:0]      search_in,                  // Search or training per lane
	input  wire logic                  lane_align_done_in,         // Lane alignment complete
	input  wire logic [LANES-1:0]      dp_data_err_in,             // Disparity or data error events
	input  wire logic [LANES-1:0]      dp_buf_err_in,              // Buffer error events
	input  wire logic [LANES-1:0]      dp_buf_ovf_in,              // Buffer overflow events
	input  wire logic [LANES-1:0]      dp_buf_unf_in,              // Buffer underflow events
	output logic      [3*LANES-1:0]    lane_pattern_type_out,      // Per-lane pattern_type_sel
	output logic      [3*LANES-1:0]    lane_prbs_length_out,       // Per-lane prbs_length_sel
	output logic      [LANES-1:0]      lane_custom_len_20_out,     // Per-lane custom_len_20
	output logic      [CP_W*LANES-1:0] lane_custom_pattern_out,    // Per-lane custom pattern
	output logic      [TO_W*LANES-1:0] lane_timeout_out,           // Per-lane timeout
	output logic      [2:0]            retain_threshold_out        // Verifier retain threshold
);
	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [LANES-1:0] load_q,     load_d;      // verifier_load strobes
	logic             cp20_q,     cp20_d;      // custom_len_20
	logic [2:0]       len_q,      len_d;       // prbs_length_sel
	logic [2:0]       ptype_q,    ptype_d;     // pattern_type_sel
	logic [CP_W-1:0]  cp_q,       cp_d;        // custom_pattern_bits
	logic [2:0]       thr_q,      thr_d;       // retain_threshold
	logic             cclr_q,     cclr_d;      // error_count_clear
	logic             cclr_old_q, cclr_old_d;  // Previous error_count_clear
	logic             fclr_q,     fclr_d;      // latched_flag_clear
	logic [2:0]       tsel_q,     tsel_d;      // test_irq_source_sel
	logic [LANES-1:0] dpen_q,     dpen_d;      // datapath_check_enable
	logic [2:0]       dpsel_q,    dpsel_d;     // datapath_check_sel
	logic [7:0]       rdata_q,    rdata_d;     // Read data
	logic [LANES-1:0] sync_q,     sync_d;      // Registered sync status
	logic [LANES-1:0] fail_q,     fail_d;      // Registered mismatch status
	logic [LANES-1:0] tip_q,      tip_d;       // Registered search status
	logic             align_q,    align_d;     // Registered alignment status
	logic [LANES-1:0] live_q,     live_d;      // test_flag_live
	logic [LANES-1:0] latch_q,    latch_d;     // latched_test_flag
	logic [CNT_W-1:0] cnt_q [LANES];           // bit_error_count per lane
	logic             cnt_clr;                 // Counter clear pulse
	logic [CP_W-1:0]  cp_eff;                  // Custom pattern after length mask

	// ----------------------------------------------------------------
	// Datapath condition decode, shared by counters and flags
	// ----------------------------------------------------------------
	function automatic logic dp_cond(input logic [2:0] sel, input logic derr, input logic berr,
		input logic ovf, input logic unf, input logic algn);
		logic r;
		r = 1'b0;
		unique case (sel)
			DC_DATA_ERR: r = derr;
			DC_BUF_ERR:  r = berr;
			DC_BUF_OVF:  r = ovf;
			DC_BUF_UNF:  r = unf;
			DC_ALIGN:    r = algn;
			default:     r = 1'b0;   // Reserved selections report nothing
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Control registers and register writes
	// ----------------------------------------------------------------
	// Next values of software-written registers
	always_comb
	begin
		load_d     = load_q;
		cp20_d     = cp20_q;
		len_d      = len_q;
		ptype_d    = ptype_q;
		cp_d       = cp_q;
		thr_d      = thr_q;
		cclr_d     = 1'b0;
		fclr_d     = 1'b0;
		cclr_old_d = cclr_q;
		tsel_d     = tsel_q;
		dpen_d     = dpen_q;
		dpsel_d    = dpsel_q;
		if (reg_wr_in)
		begin
			unique case (reg_addr_in)
				OFS_SYNC_LOAD: load_d = reg_wdata_in[LANES-1:0];
				OFS_PAT_CFG:
				begin
					cp20_d  = reg_wdata_in[POS_CP20];
					len_d   = reg_wdata_in[POS_LEN +: 3];
					ptype_d = reg_wdata_in[2:0];
				end
				OFS_CP_LOW:    cp_d[7:0]   = reg_wdata_in;
				OFS_CP_MID:    cp_d[15:8]  = reg_wdata_in;
				OFS_CP_HIGH:   cp_d[19:16] = reg_wdata_in[3:0];
				OFS_RETAIN:    thr_d = reg_wdata_in[2:0];
				OFS_TEST_CTL:
				begin
					cclr_d = reg_wdata_in[POS_CNT_CLR];
					fclr_d = reg_wdata_in[POS_FLAG_CLR];
					tsel_d = reg_wdata_in[2:0];
				end
				OFS_DP_CTL:
				begin
					dpen_d  = reg_wdata_in[POS_HI_NIB +: LANES];
					dpsel_d = reg_wdata_in[2:0];
				end
				default: ;                                       // Read-only or unmapped: ignored
			endcase
		end
	end

	// Register the control state
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			load_q     <= RST_BYTE[LANES-1:0];
			cp20_q     <= 1'b0;
			len_q      <= RST_SEL3;
			ptype_q    <= RST_SEL3;
			cp_q       <= '0;
			thr_q      <= RST_SEL3;
			cclr_q     <= 1'b0;
			cclr_old_q <= 1'b0;
			fclr_q     <= 1'b0;
			tsel_q     <= RST_SEL3;
			dpen_q     <= RST_BYTE[LANES-1:0];
			dpsel_q    <= RST_SEL3;
		end
		else if (clk_en_in)
		begin
			load_q     <= load_d;
			cp20_q     <= cp20_d;
			len_q      <= len_d;
			ptype_q    <= ptype_d;
			cp_q       <= cp_d;
			thr_q      <= thr_d;
			cclr_q     <= cclr_d;
			cclr_old_q <= cclr_old_d;
			fclr_q     <= fclr_d;
			tsel_q     <= tsel_d;
			dpen_q     <= dpen_d;
			dpsel_q    <= dpsel_d;
		end
	end

	// Counters clear only on the rising edge of the clear bit
	assign cnt_clr = cclr_q & ~cclr_old_q;
	// Upper custom bits take part only in 20-bit mode
	assign cp_eff  = cp20_q ? cp_q : {4'h0, cp_q[15:0]};
	assign retain_threshold_out = thr_q;

	// ----------------------------------------------------------------
	// Per-lane settings capture and error counters
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : g_lane
			logic [2:0]       pt_q,  pt_d;   // Captured pattern type
			logic [2:0]       ln_q,  ln_d;   // Captured length
			logic             c20_q, c20_d;  // Captured custom length
			logic [CP_W-1:0]  pat_q, pat_d;  // Captured custom pattern
			logic [TO_W-1:0]  to_q,  to_d;   // Captured timeout
			logic [CNT_W-1:0] c_d;           // Next error count
			logic             ev;            // Counted error event

			// Follow live settings while loading, hold otherwise
			always_comb
			begin
				pt_d  = pt_q;
				ln_d  = ln_q;
				c20_d = c20_q;
				pat_d = pat_q;
				to_d  = to_q;
				if (load_q[g])
				begin
					pt_d  = ptype_q;
					ln_d  = len_q;
					c20_d = cp20_q;
					pat_d = cp_eff;
					to_d  = verifier_timeout_ctl_in;
				end
			end

			// Error event of this lane, counted only while checking is on
			always_comb
			begin
				ev = dpen_q[g] && (dpsel_q != DC_ALIGN) &&
					dp_cond(dpsel_q, dp_data_err_in[g], dp_buf_err_in[g],
						dp_buf_ovf_in[g], dp_buf_unf_in[g], lane_align_done_in);
				c_d = cnt_q[g];
				if (cnt_clr)
					c_d = {{(CNT_W-1){1'b0}}, ev};
				else if (ev && cnt_q[g] != CNT_MAX)
					c_d = cnt_q[g] + 12'h001;
			end

			// Register captured settings and the count
			always_ff @(posedge clk_sys_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
				begin
					pt_q     <= RST_SEL3;
					ln_q     <= RST_SEL3;
					c20_q    <= 1'b0;
					pat_q    <= '0;
					to_q     <= '0;
					cnt_q[g] <= '0;
				end
				else if (clk_en_in)
				begin
					pt_q     <= pt_d;
					ln_q     <= ln_d;
					c20_q    <= c20_d;
					pat_q    <= pat_d;
					to_q     <= to_d;
					cnt_q[g] <= c_d;
				end
			end

			assign lane_pattern_type_out[3*g +: 3]      = pt_q;
			assign lane_prbs_length_out[3*g +: 3]       = ln_q;
			assign lane_custom_len_20_out[g]            = c20_q;
			assign lane_custom_pattern_out[CP_W*g +: CP_W] = pat_q;
			assign lane_timeout_out[TO_W*g +: TO_W]     = to_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Status capture and test flags
	// ----------------------------------------------------------------
	// Select each lane's test condition; latch it until cleared
	always_comb
	begin
		sync_d  = pattern_sync_pulse_in;
		fail_d  = mismatch_in;
		tip_d   = search_in;
		align_d = lane_align_done_in;
		for (int i = 0; i < LANES; i++)
		begin
			unique case (tsel_q)
				TS_MISMATCH: live_d[i] = mismatch_in[i];
				TS_SEARCH:   live_d[i] = search_in[i];
				TS_SYNC:     live_d[i] = pattern_sync_pulse_in[i];
				TS_DATAPATH: live_d[i] = dpen_q[i] && dp_cond(dpsel_q, dp_data_err_in[i],
					dp_buf_err_in[i], dp_buf_ovf_in[i], dp_buf_unf_in[i], lane_align_done_in);
				default:     live_d[i] = 1'b0;                           // No source
			endcase
		end
		// New condition wins over a clear in the same cycle
		latch_d = (fclr_q ? '0 : latch_q) | live_q;
	end

	// Register status and flags
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sync_q  <= '0;
			fail_q  <= '0;
			tip_q   <= '0;
			align_q <= 1'b0;
			live_q  <= '0;
			latch_q <= '0;
		end
		else if (clk_en_in)
		begin
			sync_q  <= sync_d;
			fail_q  <= fail_d;
			tip_q   <= tip_d;
			align_q <= align_d;
			live_q  <= live_d;
			latch_q <= latch_d;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	// Read multiplexer; unmapped offsets read zero
	always_comb
	begin
		rdata_d = rdata_q;
		if (reg_rd_in)
		begin
			rdata_d = RST_BYTE;
			unique case (reg_addr_in)
				OFS_SYNC_LOAD:  rdata_d = {sync_q, load_q};
				OFS_RESULT:     rdata_d = {fail_q, tip_q};
				OFS_PAT_CFG:    rdata_d = {cp20_q, 1'b0, len_q, ptype_q};
				OFS_CP_LOW:     rdata_d = cp_q[7:0];
				OFS_CP_MID:     rdata_d = cp_q[15:8];
				OFS_CP_HIGH:    rdata_d = {4'h0, cp_q[19:16]};
				OFS_RETAIN:     rdata_d = {5'h00, thr_q};
				OFS_TEST_CTL:   rdata_d = {align_q, 2'b00, cclr_q, fclr_q, tsel_q};
				OFS_DP_CTL:     rdata_d = {dpen_q, 1'b0, dpsel_q};
				OFS_TEST_FLAGS: rdata_d = {latch_q, live_q};
				default:
				begin
					for (int i = 0; i < LANES; i++)
					begin
						if (reg_addr_in == OFS_CNT_BASE + 8'(2*i))
							rdata_d = cnt_q[i][7:0];
						else if (reg_addr_in == OFS_CNT_BASE + 8'(2*i+1))
							rdata_d = {4'h0, cnt_q[i][11:8]};
					end
				end
			endcase
		end
	end

	// Register read data
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rdata_q <= RST_BYTE;
		else if (clk_en_in)
			rdata_q <= rdata_d;
	end

	assign reg_rdata_out = rdata_q;
endmodule // lpv_top

// File: lpv_checker_asserts.sv
// Checker of the lane pattern verifier register port and lane settings.
// Assumes only the ports of lpv_top; bound to it at the foot of this file.
`timescale 1ns/1ps
module lpv_checker
	import lpv_pkg::*;
(
	input wire logic [7:0]            reg_addr_in,             // Register offset
	input wire logic                  clk_sys_in,              // System clock
	input wire logic                  rst_n_in,                // Reset, active low
	input wire logic                  clk_en_in,               // Clock enable
	input wire logic                  reg_wr_in,               // Write strobe
	input wire logic [7:0]            reg_wdata_in,            // Write data
	input wire logic                  reg_rd_in,               // Read strobe
	input wire logic [7:0]            reg_rdata_out,           // Read data
	input wire logic [LANES-1:0]      pattern_sync_pulse_in,   // Sync pulses
	input wire logic [LANES-1:0]      mismatch_in,             // Mismatch status
	input wire logic [LANES-1:0]      search_in,               // Search status
	input wire logic                  lane_align_done_in,      // Alignment status
	input wire logic [3*LANES-1:0]    lane_pattern_type_out,   // Lane types
	input wire logic [3*LANES-1:0]    lane_prbs_length_out,    // Lane lengths
	input wire logic [LANES-1:0]      lane_custom_len_20_out,  // Lane custom lengths
	input wire logic [CP_W*LANES-1:0] lane_custom_pattern_out, // Lane patterns
	input wire logic [2:0]            retain_threshold_out     // Retain threshold
);
	// --------
	// Helpers
	// --------
	logic rd_go; // Read taken this edge
	assign rd_go = reg_rd_in && clk_en_in;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// --------
	// Properties
	// --------
	property p_sync_rd;
		rd_go && reg_addr_in == OFS_SYNC_LOAD && $past(clk_en_in) |=> reg_rdata_out[7:4] == $past(pattern_sync_pulse_in, 2);
	endproperty
	a_sync_rd: assert property (p_sync_rd) else $error("sync status read wrong");
	property p_result_rd;
		rd_go && reg_addr_in == OFS_RESULT && $past(clk_en_in) |=> reg_rdata_out == $past({mismatch_in, search_in}, 2);
	endproperty
	a_result_rd: assert property (p_result_rd) else $error("result status read wrong");
	property p_align_rd;
		rd_go && reg_addr_in == OFS_TEST_CTL && $past(clk_en_in) |=> reg_rdata_out[POS_ALIGN] == $past(lane_align_done_in, 2);
	endproperty
	a_align_rd: assert property (p_align_rd) else $error("alignment status read wrong");
	property p_lane_hold;
		!reg_wr_in [*3] |=> $stable(lane_pattern_type_out) && $stable(lane_prbs_length_out)
			&& $stable(lane_custom_len_20_out) && $stable(lane_custom_pattern_out);
	endproperty
	a_lane_hold: assert property (p_lane_hold) else $error("lane settings moved without a write");
	property p_cp16;
		lane_custom_len_20_out != 4'hf |-> (lane_custom_len_20_out[0] || lane_custom_pattern_out[19:16] == 4'h0)
			&& (lane_custom_len_20_out[1] || lane_custom_pattern_out[39:36] == 4'h0)
			&& (lane_custom_len_20_out[2] || lane_custom_pattern_out[59:56] == 4'h0)
			&& (lane_custom_len_20_out[3] || lane_custom_pattern_out[79:76] == 4'h0);
	endproperty
	a_cp16: assert property (p_cp16) else $error("upper custom bits used in 16-bit mode");
	property p_unmapped;
		rd_go && (reg_addr_in < OFS_SYNC_LOAD || reg_addr_in > 8'h1f) |=> reg_rdata_out == RST_BYTE;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rdata_hold;
		!rd_go |=> $stable(reg_rdata_out);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
	property p_freeze;
		!clk_en_in |=> $stable(lane_custom_pattern_out) && $stable(retain_threshold_out) && $stable(reg_rdata_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
	property p_thr;
		reg_wr_in && clk_en_in && reg_addr_in == OFS_RETAIN |=> retain_threshold_out == $past(reg_wdata_in[2:0]);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold not written");
endmodule // lpv_checker

bind lpv_top lpv_checker u_lpv_checker (.clk_sys_in, .rst_n_in, .clk_en_in, .reg_addr_in, .reg_wr_in,
	.reg_wdata_in, .reg_rd_in, .reg_rdata_out, .pattern_sync_pulse_in, .mismatch_in, .search_in,
	.lane_align_done_in, .lane_pattern_type_out, .lane_prbs_length_out, .lane_custom_len_20_out,
	.lane_custom_pattern_out, .retain_threshold_out);

// File: lane_pattern_verifier_bert_test.sv
// Self-checking bench of the lane pattern verifier register block.
// Assumes lpv_top and its package; reads are checked from a queue of expected bytes.
`timescale 1ns/1ps
module lane_pattern_verifier_bert_test
	import lpv_pkg::*;
;
	logic                  clk_sys_in, rst_n_in, clk_en_in, reg_wr_in, reg_rd_in, lane_align_done_in, rd_d;
	logic [7:0]            reg_addr_in, reg_wdata_in, reg_rdata_out, exp_q[$];
	logic [TO_W-1:0]       verifier_timeout_ctl_in;
	logic [LANES-1:0]      pattern_sync_pulse_in, mismatch_in, search_in, lane_custom_len_20_out, ev, en, src, lv;
	logic [LANES-1:0]      dp_data_err_in, dp_buf_err_in, dp_buf_ovf_in, dp_buf_unf_in, loaded;
	logic [3*LANES-1:0]    lane_pattern_type_out, lane_prbs_length_out;
	logic [CP_W*LANES-1:0] lane_custom_pattern_out;
	logic [TO_W*LANES-1:0] lane_timeout_out;
	logic [2:0]            retain_threshold_out;
	int                    n_mismatch, compares, seed, cnt[LANES];
	// --------
	// Design and clock
	// --------
	lpv_top u_lpv_top (.clk_sys_in, .rst_n_in, .clk_en_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in,
		.reg_rdata_out, .verifier_timeout_ctl_in, .pattern_sync_pulse_in, .mismatch_in, .search_in,
		.lane_align_done_in, .dp_data_err_in, .dp_buf_err_in, .dp_buf_ovf_in, .dp_buf_unf_in,
		.lane_pattern_type_out, .lane_prbs_length_out, .lane_custom_len_20_out, .lane_custom_pattern_out,
		.lane_timeout_out, .retain_threshold_out);
	initial
	begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	// --------
	// Tasks
	// --------
	task automatic check(input logic [19:0] seen, input logic [19:0] want);
		compares++;
		if (seen !== want)
		begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		// Lanes ever loaded hold the timeout input from then on
		if (a == OFS_SYNC_LOAD)
			loaded |= d[LANES-1:0];
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask
	// Read strobe; expected byte noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		exp_q.push_back(e);
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// Compare one lane's settings outputs
	task automatic lane_chk(input int n, input logic [2:0] ty, input logic [2:0] ln, input logic c20,
		input logic [19:0] cp);
		check(lane_pattern_type_out[3*n+:3], ty);
		check(lane_prbs_length_out[3*n+:3], ln);
		check(lane_custom_len_20_out[n], c20);
		check(lane_custom_pattern_out[20*n+:20], cp);
		check(lane_timeout_out[3*n+:3], loaded[n] ? verifier_timeout_ctl_in : 3'h0);
	endtask
	// --------
	// Watcher: read data one cycle after a taken read
	// --------
	always @(posedge clk_sys_in)
		rd_d <= reg_rd_in && clk_en_in && rst_n_in;
	always @(negedge clk_sys_in)
		if (rd_d)
			check(reg_rdata_out, exp_q.pop_front());
	// --------
	// Watchdog
	// --------
	initial
	begin
		#(50 * 20000);
		n_mismatch++;
		test_done();
	end
	// --------
	// Main sequence
	// --------
	initial
	begin
		seed = 20193;
		{rst_n_in, reg_wr_in, reg_rd_in, lane_align_done_in, reg_addr_in, reg_wdata_in} = '0;
		{pattern_sync_pulse_in, mismatch_in, search_in} = '0;
		{dp_data_err_in, dp_buf_err_in, dp_buf_ovf_in, dp_buf_unf_in, loaded} = '0;
		clk_en_in = 1'b1;
		verifier_timeout_ctl_in = 3'($random(seed));
		idle(6);
		rst_n_in <= 1'b1;
		for (int a = 5; a < 34; a += (a == 5) ? 9 : 1)
			rd(8'(a), RST_BYTE);
		wr(OFS_PAT_CFG, 8'hcb);
		rd(OFS_PAT_CFG, 8'h8b);
		wr(OFS_CP_LOW, 8'ha5);
		wr(OFS_CP_MID, 8'h3c);
		wr(OFS_CP_HIGH, 8'hf9);
		rd(OFS_CP_HIGH, 8'h09);
		wr(OFS_RETAIN, 8'hff);
		rd(OFS_RETAIN, 8'h07);
		check(retain_threshold_out, 20'h7);
		wr(OFS_SYNC_LOAD, 8'h05);
		idle(2);
		for (int n = 0; n < LANES; n++)
			lane_chk(n, n[0] ? 3'h0 : 3'h3, n[0] ? 3'h0 : 3'h1, !n[0], n[0] ? 20'h0 : 20'h93ca5);
		wr(OFS_SYNC_LOAD, 8'h00);
		wr(OFS_PAT_CFG, 8'h02);
		wr(OFS_SYNC_LOAD, 8'h0a);
		idle(2);
		lane_chk(0, 3'h3, 3'h1, 1'b1, 20'h93ca5);
		lane_chk(1, 3'h2, 3'h0, 1'b0, 20'h03ca5);
		for (int v = 0; v < 8; v++)
		begin
			wr(OFS_PAT_CFG, {2'b00, 3'(v), ~3'(v)});
			idle(2);
			lane_chk(3, ~3'(v), 3'(v), 1'b0, 20'h03ca5);
		end
		repeat (4)
		begin
			{pattern_sync_pulse_in, mismatch_in, search_in, lane_align_done_in} <= 13'($random(seed));
			idle(1);
			rd(OFS_SYNC_LOAD, {pattern_sync_pulse_in, 4'ha});
			rd(OFS_RESULT, {mismatch_in, search_in});
			rd(OFS_TEST_CTL, {lane_align_done_in, 7'h00});
		end
		// Quiet status first, so no stale live flag survives the first clear
		{pattern_sync_pulse_in, mismatch_in, search_in} <= '0;
		for (int ts = 0; ts < 5; ts++)
		begin
			wr(OFS_TEST_CTL, {5'b00001, 3'(ts)});
			src = 4'($random(seed)) | 4'h1;
			lv = ts == 0 ? src : ts == 1 ? ~src : ts == 2 ? src ^ 4'h5 : 4'h0;
			mismatch_in <= src;
			search_in <= ~src;
			pattern_sync_pulse_in <= src ^ 4'h5;
			idle(3);
			rd(OFS_TEST_FLAGS, {lv, lv});
			{pattern_sync_pulse_in, mismatch_in, search_in} <= '0;
			idle(3);
			rd(OFS_TEST_FLAGS, {lv, 4'h0});
			wr(OFS_TEST_CTL, {5'b00001, 3'(ts)});
			idle(2);
			rd(OFS_TEST_FLAGS, 8'h00);
			rd(OFS_TEST_CTL, {lane_align_done_in, 4'h0, 3'(ts)});
		end
		for (int s = 0; s < 6; s++)
		begin
			en = 4'($random(seed));
			wr(OFS_DP_CTL, {en, 1'b0, 3'(s)});
			wr(OFS_TEST_CTL, 8'h10);
			idle(2);
			cnt = '{default: 0};
			for (int i = 0; i < 20; i++)
			begin
				ev = 4'($random(seed));
				clk_en_in <= !(i == 5 || i == 6);
				dp_data_err_in <= s == 0 ? ev : ~ev;
				dp_buf_err_in <= s == 1 ? ev : ~ev;
				dp_buf_ovf_in <= s == 2 ? ev : ~ev;
				dp_buf_unf_in <= s == 3 ? ev : ~ev;
				for (int n = 0; n < LANES; n++)
					cnt[n] += (s < 4 && i != 5 && i != 6) ? int'(ev[n] & en[n]) : 0;
				idle(1);
			end
			{dp_data_err_in, dp_buf_err_in, dp_buf_ovf_in, dp_buf_unf_in} <= '0;
			clk_en_in <= 1'b1;
			idle(2);
			for (int n = 0; n < LANES; n++)
			begin
				rd(OFS_CNT_BASE + 8'(2 * n), 8'(cnt[n]));
				rd(OFS_CNT_BASE + 8'(2 * n + 1), 8'h00);
			end
		end
		idle(4);
		test_done();
	end
endmodule // lane_pattern_verifier_bert_test
